// File: ebw_wait_counter.sv
`timescale 1ns/1ps
`default_nettype none

package ebw_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS        = 10;          // Core clock period
   localparam int unsigned HALF_CLOCK_PERIOD_NS = 25;          // Bus half clock period
   // Least time, so round up to whole core cycles
   localparam int unsigned HALF_CYC_DEF =
      (HALF_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_SYSCFG = 8'h00;  // System configuration
   localparam logic [7:0] OFS_ADDR   = 8'h04;  // Access address
   localparam logic [7:0] OFS_WDATA  = 8'h08;  // Write data
   localparam logic [7:0] OFS_CTRL   = 8'h0c;  // Start command
   localparam logic [7:0] OFS_STATUS = 8'h10;  // Busy flag
   localparam logic [7:0] OFS_RDATA  = 8'h14;  // Last read data

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CWF_LSB     = 0;    // Cycle wait field, 4 bits
   localparam int unsigned TWB_BIT     = 4;    // Tristate wait bit
   localparam int unsigned MODE_LSB    = 6;    // Captured bus mode, 2 bits
   localparam int unsigned UBE_OFF_BIT = 8;    // Upper byte enable disabled
   localparam int unsigned CTRL_GO     = 0;    // Start a bus cycle
   localparam int unsigned CTRL_WR     = 1;    // 1 write, 0 read
   localparam int unsigned CTRL_BYTE   = 2;    // 1 byte, 0 word
   localparam logic [3:0]  CWF_RST     = 4'h0; // Slowest timing after reset
   localparam logic        TWB_RST     = 1'b0; // Float wait on after reset
   localparam logic [3:0]  CWF_INV     = 4'hf; // Field holds this minus waits

   // ----------------------------------------------------------------
   // Bus cycle lengths in half clock periods
   // ----------------------------------------------------------------
   localparam logic [5:0] MUX_ADDR_H = 6'd2;
   localparam logic [5:0] MUX_STRB_H = 6'd4;
   localparam logic [5:0] NMX_ADDR_H = 6'd1;
   localparam logic [5:0] NMX_STRB_H = 6'd3;
   localparam logic [5:0] FLOAT_H    = 6'd2;   // One wait state

   // ----------------------------------------------------------------
   // Bus modes captured from the configuration pins
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_NMX16 = 2'b00;
   localparam logic [1:0] MODE_MUX8  = 2'b01;
   localparam logic [1:0] MODE_MUX16 = 2'b10;
   localparam logic [1:0] MODE_NMX_B = 2'b11;

   // Multiplexed modes share one bus
   function automatic logic is_mux(input logic [1:0] m);
      is_mux = (m == MODE_MUX8) || (m == MODE_MUX16);
   endfunction

   // Cycle waits decoded from the inverted field
   function automatic logic [4:0] cycle_waits(input logic [3:0] cwf);
      cycle_waits = {1'b0, CWF_INV - cwf};
   endfunction
endpackage

// --------------------------------------------------------------------
// Half period timer: counts load_h half periods of HALF_CYC cycles
// --------------------------------------------------------------------
module ebw_wait_counter
#(
   parameter int unsigned HALF_CYC = ebw_pkg::HALF_CYC_DEF
)
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_load,
   input  wire logic [5:0] i_load_h,
   output logic            o_done
);
   import ebw_pkg::*;

   logic [5:0] half_left;   // Half periods still to run
   logic [7:0] sub_left;    // Core cycles left in this half period
   logic       active;      // Timer running

   // Done in the last core cycle of the last half period
   assign o_done = active && (half_left == 6'd0) && (sub_left == 8'd0);

   // Divider and half period count
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         half_left <= 6'd0;
         sub_left  <= 8'd0;
         active    <= 1'b0;
      end
      else if (i_load)
      begin
         half_left <= i_load_h - 6'd1;
         sub_left  <= 8'(HALF_CYC - 1);
         active    <= 1'b1;
      end
      else if (o_done)
         active <= 1'b0;
      else if (active)
      begin
         // Enable pulse each HALF_CYC cycles steps the half count
         if (sub_left == 8'd0)
         begin
            sub_left  <= 8'(HALF_CYC - 1);
            half_left <= half_left - 6'd1;
         end
         else
            sub_left <= sub_left - 8'd1;
      end
   end
endmodule // ebw_wait_counter

`default_nettype wire

// File: ebw_bus_ctrl.sv
// Operation
// - Bus mode taken from config pins during reset
// - Only 64K space, no segment address outputs
// - Multiplexed 8-bit: address first, then data
// - Byte lanes: A0 low, upper enable high
// - Non-multiplexed: separate address and data buses
// - Read waits: max count plus float count
// - Float wait is zero or one
// - Write waits: max count, no float term
// - Waits programmable in single steps
// - Field holds 15 minus waits, inverted float
// - Wait fields live in config register
// - Multiplexed cycle six halves plus two each
// - Non-multiplexed cycle four halves plus two each
`timescale 1ns/1ps
`default_nettype none

module ebw_bus_ctrl
#(
   parameter int unsigned HALF_CYC = ebw_pkg::HALF_CYC_DEF  // Core cycles per half period
)
(
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RESETN,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_BUS_CONFIG_PIN_HI,
   input  wire logic        I_BUS_CONFIG_PIN_LO,
   input  wire logic [15:0] I_AD,
   output logic      [15:0] O_AD,
   output logic             O_AD_OE_N,
   output logic      [15:0] O_ADDR,
   output logic             O_ALE,
   output logic             O_RD_N,
   output logic             O_WR_N,
   output logic             O_UPPER_BYTE_ENABLE_N
);
   import ebw_pkg::*;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   typedef enum logic [3:0]
   {
      S_IDLE  = 4'b0001,
      S_ADDR  = 4'b0010,
      S_STRB  = 4'b0100,
      S_FLOAT = 4'b1000
   } ebw_state_e;

   ebw_state_e  st;              // Bus cycle state
   logic [1:0]  cfg_s1;          // Pin synchroniser, first stage
   logic [1:0]  cfg_s2;          // Pin synchroniser, second stage
   logic [1:0]  mode;            // Captured bus mode
   logic [15:0] ad_s1;           // Data pin synchroniser
   logic [15:0] ad_s2;
   logic [3:0]  cwf;             // Cycle wait field
   logic        twb;             // Tristate wait bit
   logic        ube_off;         // Upper byte enable disabled
   logic [15:0] addr_reg;        // Software address, 64K only
   logic [15:0] wdata_reg;       // Software write data
   logic [15:0] rdata_reg;       // Last read result
   logic [15:0] req_addr;        // Latched cycle address
   logic [15:0] req_wdata;       // Latched lane data
   logic        req_wr;          // Cycle is a write
   logic        req_byte;        // Cycle is a byte access
   logic        req_float;       // Float wait requested
   logic [4:0]  req_cw;          // Cycle waits for this cycle
   logic        mux;             // Shared bus in use
   logic        wide;            // 16-bit data bus
   logic        apb_wr;          // Write takes effect
   logic        apb_setup_rd;    // Read data prepared
   logic        start;           // New bus cycle
   logic        t_load;          // Timer load
   logic [5:0]  t_load_h;        // Timer length
   logic        t_done;          // Timer expired
   logic [15:0] next_rdata;      // Lane-selected read value

   assign mux  = is_mux(mode);
   assign wide = (mode != MODE_MUX8);

   // APB takes a write only in the access phase; PREADY is high from the second cycle after reset
   assign apb_wr       = I_PSEL && I_PENABLE && I_PWRITE;
   assign apb_setup_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
   assign start        = apb_wr && (I_PADDR == OFS_CTRL) && I_PWDATA[CTRL_GO] && (st == S_IDLE);

   // -----------------------------------------------------------------
   // Configuration pins
   // -----------------------------------------------------------------
   // Two-stage synchroniser, no reset so the pins show during reset
   always_ff @(posedge I_CORE_CLK)
   begin
      cfg_s1 <= {I_BUS_CONFIG_PIN_HI, I_BUS_CONFIG_PIN_LO};
      cfg_s2 <= cfg_s1;
      ad_s1  <= I_AD;
      ad_s2  <= ad_s1;
   end

   // Mode follows the pins while reset is held, frozen after release
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RESETN)
         mode <= cfg_s2;
   end

   // -----------------------------------------------------------------
   // Register file
   // -----------------------------------------------------------------
   // Configuration register, wait fields reset to slowest timing
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RESETN)
      begin
         cwf     <= CWF_RST;
         twb     <= TWB_RST;
         ube_off <= 1'b0;
      end
      else if (apb_wr && (I_PADDR == OFS_SYSCFG))
      begin
         cwf     <= I_PWDATA[CWF_LSB +: 4];
         twb     <= I_PWDATA[TWB_BIT];
         ube_off <= I_PWDATA[UBE_OFF_BIT];
      end
   end

   // Address and write data; 16 bits only, no segment bits
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RESETN)
      begin
         addr_reg  <= 16'h0000;
         wdata_reg <= 16'h0000;
      end
      else if (apb_wr)
      begin
         if (I_PADDR == OFS_ADDR)
            addr_reg <= I_PWDATA[15:0];
         if (I_PADDR == OFS_WDATA)
            wdata_reg <= I_PWDATA[15:0];
      end
   end

   // Read data and error prepared in setup, stable through access
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RESETN)
      begin
         O_PRDATA  <= 32'h0000_0000;
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
      end
      else
      begin
         O_PREADY <= 1'b1;
         if (I_PSEL && !I_PENABLE)
         begin
            // Unmapped offsets answer with an error
            O_PSLVERR <= !(I_PADDR == OFS_SYSCFG || I_PADDR == OFS_ADDR ||
                           I_PADDR == OFS_WDATA  || I_PADDR == OFS_CTRL ||
                           I_PADDR == OFS_STATUS || I_PADDR == OFS_RDATA);
         end
         if (apb_setup_rd)
         begin
            case (I_PADDR)
               OFS_SYSCFG : O_PRDATA <= {23'h0, ube_off, mode, 1'b0, twb, cwf};
               OFS_ADDR   : O_PRDATA <= {16'h0, addr_reg};
               OFS_WDATA  : O_PRDATA <= {16'h0, wdata_reg};
               OFS_STATUS : O_PRDATA <= {31'h0, (st != S_IDLE)};
               OFS_RDATA  : O_PRDATA <= {16'h0, rdata_reg};
               default    : O_PRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Bus cycle timing
   // -----------------------------------------------------------------
   // Timer reloads on start, at the end of the address phase and at the end of the strobe of a read with float wait
   always_comb
   begin
      t_load   = 1'b0;
      t_load_h = 6'd1;
      case (st)
         S_IDLE :
         begin
            t_load   = start;
            t_load_h = mux ? MUX_ADDR_H : NMX_ADDR_H;
         end
         S_ADDR :
         begin
            // Each wait state adds two half periods
            t_load   = t_done;
            t_load_h = (mux ? MUX_STRB_H : NMX_STRB_H) + {req_cw, 1'b0};
         end
         S_STRB :
         begin
            t_load   = t_done && !req_wr && req_float;
            t_load_h = FLOAT_H;
         end
         default :
         begin
            t_load   = 1'b0;
            t_load_h = 6'd1;
         end
      endcase
   end

   ebw_wait_counter #(.HALF_CYC(HALF_CYC)) u_timer
   (
      .i_clk    (I_CORE_CLK),
      .i_rst_n  (I_RESETN),
      .i_load   (t_load),
      .i_load_h (t_load_h),
      .o_done   (t_done)
   );

   // Byte from the lane A0 names; word as is
   assign next_rdata = !req_byte ? ad_s2 :
                       (req_addr[0] && wide) ? {8'h00, ad_s2[15:8]} : {8'h00, ad_s2[7:0]};

   // -----------------------------------------------------------------
   // Bus cycle state machine and pins
   // -----------------------------------------------------------------
   // Pins change together with the state so every output is a flop
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RESETN)
      begin
         st        <= S_IDLE;
         O_ALE     <= 1'b0;
         O_RD_N    <= 1'b1;
         O_WR_N    <= 1'b1;
         O_AD      <= 16'h0000;
         O_AD_OE_N <= 1'b1;
         O_ADDR    <= 16'h0000;
         O_UPPER_BYTE_ENABLE_N <= 1'b1;
         req_addr  <= 16'h0000;
         req_wdata <= 16'h0000;
         req_wr    <= 1'b0;
         req_byte  <= 1'b0;
         req_float <= 1'b0;
         req_cw    <= 5'd0;
         rdata_reg <= 16'h0000;
      end
      else
      begin
         case (st)
            S_IDLE :
            begin
               if (start)
               begin
                  st        <= S_ADDR;
                  req_wr    <= I_PWDATA[CTRL_WR];
                  // Narrow bus carries bytes only
                  req_byte  <= I_PWDATA[CTRL_BYTE] || !wide;
                  // Words are aligned, A0 low
                  req_addr  <= {addr_reg[15:1], addr_reg[0] && (I_PWDATA[CTRL_BYTE] || !wide)};
                  // Byte data copied to both lanes
                  req_wdata <= (I_PWDATA[CTRL_BYTE] || !wide) ?
                               {wdata_reg[7:0], wdata_reg[7:0]} : wdata_reg;
                  req_cw    <= cycle_waits(cwf);
                  req_float <= !twb;
                  O_ALE     <= 1'b1;
                  // Upper lane active for words or odd bytes on a wide bus with the enable not disabled
                  O_UPPER_BYTE_ENABLE_N <= !(wide && !ube_off &&
                     (!(I_PWDATA[CTRL_BYTE]) || addr_reg[0]));
                  if (mux)
                  begin
                     // Address first on the shared bus for the latch
                     O_AD      <= {addr_reg[15:1], addr_reg[0] && (I_PWDATA[CTRL_BYTE] || !wide)};
                     O_AD_OE_N <= 1'b0;
                  end
                  else
                     O_ADDR <= {addr_reg[15:1], addr_reg[0] && (I_PWDATA[CTRL_BYTE] || !wide)};
               end
            end
            S_ADDR :
            begin
               if (t_done)
               begin
                  st    <= S_STRB;
                  O_ALE <= 1'b0;
                  if (req_wr)
                  begin
                     O_WR_N    <= 1'b0;
                     O_AD      <= req_wdata;
                     O_AD_OE_N <= 1'b0;
                  end
                  else
                  begin
                     // Release the bus so memory can drive it
                     O_RD_N    <= 1'b0;
                     O_AD_OE_N <= 1'b1;
                  end
               end
            end
            S_STRB :
            begin
               if (t_done)
               begin
                  O_RD_N    <= 1'b1;
                  O_WR_N    <= 1'b1;
                  O_AD_OE_N <= 1'b1;
                  if (!req_wr)
                     rdata_reg <= next_rdata;
                  // Float wait only on reads
                  st <= (!req_wr && req_float) ? S_FLOAT : S_IDLE;
               end
            end
            S_FLOAT :
            begin
               // Bus stays released until the float wait ends
               if (t_done)
                  st <= S_IDLE;
            end
            default :
               st <= S_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   logic [15:0] cyc_cnt;    // Cycles spent in the current bus cycle
   logic [15:0] exp_cyc;    // Expected length from the raw fields
   logic [7:0]  flt_cnt;    // Cycles in the float phase
   logic        was_busy;   // Previous cycle was busy

   // Helper counters only the checks read
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_RESETN)
      begin
         cyc_cnt  <= 16'h0000;
         exp_cyc  <= 16'h0000;
         flt_cnt  <= 8'h00;
         was_busy <= 1'b0;
      end
      else
      begin
         was_busy <= (st != S_IDLE);
         cyc_cnt  <= (st == S_IDLE) ? 16'h0000 : cyc_cnt + 16'h0001;
         flt_cnt  <= (st == S_FLOAT) ? flt_cnt + 8'h01 : 8'h00;
         if (start)
            exp_cyc <= 16'(((mux ? 6 : 4) + 2 * ((15 - int'(cwf)) +
                       ((!I_PWDATA[CTRL_WR] && !twb) ? 1 : 0))) * HALF_CYC);
      end
   end

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESETN);

   property p_mode_frozen;
      $past(I_RESETN) |-> $stable(mode);
   endproperty
   a_mode_frozen : assert property (p_mode_frozen) else $error("mode changed after reset");

   property p_mode_readback;
      apb_setup_rd && (I_PADDR == OFS_SYSCFG) |=> (O_PRDATA[MODE_LSB +: 2] == mode);
   endproperty
   a_mode_readback : assert property (p_mode_readback) else $error("config readback wrong");

   property p_read_len;
      (st == S_IDLE) && was_busy && !req_wr |-> (cyc_cnt == exp_cyc);
   endproperty
   a_read_len : assert property (p_read_len) else $error("read cycle length wrong");

   property p_write_len;
      (st == S_IDLE) && was_busy && req_wr |-> (cyc_cnt == exp_cyc);
   endproperty
   a_write_len : assert property (p_write_len) else $error("write cycle length wrong");

   property p_float_bound;
      (st == S_FLOAT) |-> (flt_cnt < 8'(2 * HALF_CYC));
   endproperty
   a_float_bound : assert property (p_float_bound) else $error("float wait too long");

   property p_float_released;
      $rose(O_RD_N) && req_float |-> (O_AD_OE_N && O_WR_N) [*2];
   endproperty
   a_float_released : assert property (p_float_released) else $error("bus driven in float");

   property p_mux_addr_first;
      mux && $rose(O_ALE) |-> !O_AD_OE_N && (O_AD == req_addr) && O_RD_N && O_WR_N;
   endproperty
   a_mux_addr_first : assert property (p_mux_addr_first) else $error("address not first");

   property p_byte_lane;
      (!O_RD_N || !O_WR_N) && wide && !ube_off |->
         (O_UPPER_BYTE_ENABLE_N == (req_byte && !req_addr[0]));
   endproperty
   a_byte_lane : assert property (p_byte_lane) else $error("upper byte enable wrong");

   property p_nmx_buses;
      !mux && !O_WR_N |-> (O_ADDR == req_addr) && !O_AD_OE_N && (O_AD == req_wdata);
   endproperty
   a_nmx_buses : assert property (p_nmx_buses) else $error("separate buses wrong");

   c_mux_read_float : cover property (mux && $rose(st == S_FLOAT));
   c_nmx_write      : cover property (!mux && $fell(O_WR_N));
   c_byte_hi_read   : cover property ($fell(O_RD_N) && req_byte && req_addr[0]);

endmodule // ebw_bus_ctrl

`default_nettype wire

// File: ebw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// External memory behind latches
// --------------------------------
module ebw_mem_model
(
   input  wire logic        i_clk,
   input  wire logic        i_mux,
   input  wire logic [15:0] i_ad,
   input  wire logic [15:0] i_addr,
   input  wire logic        i_ale,
   input  wire logic        i_rd_n,
   input  wire logic        i_wr_n,
   input  wire logic        i_ube_n,
   output logic      [15:0] o_ad
);
   logic [15:0] mem [0:255];    // Word store, two byte lanes
   logic [15:0] lat;            // Latched address
   logic [15:0] last;           // Last value driven
   // Latches hold full address, lanes written per enable
   always_ff @(posedge i_clk)
   begin
      if (i_ale)
      begin
         lat <= i_mux ? i_ad : i_addr;
      end
      if (!i_wr_n && !i_ube_n)
      begin
         mem[lat[8:1]][15:8] <= i_ad[15:8];
      end
      if (!i_wr_n && !lat[0])
      begin
         mem[lat[8:1]][7:0] <= i_ad[7:0];
      end
      if (!i_rd_n)
      begin
         last <= mem[lat[8:1]];
      end
   end
   // Released bus shows no stale copy, so a late sample fails
   assign o_ad = i_rd_n ? ~last : mem[lat[8:1]];
endmodule // ebw_mem_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ebw_pkg::*;
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
   logic        cfg_hi = 0, cfg_lo = 0, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   wire logic [31:0] prdata;
   wire logic        pready, pslverr, oe_n, ale, rd_n, wr_n, ube_n;
   wire logic [15:0] ad_in, ad_out, addr;
   int errors = 0;
   int check_count = 0;
   int polls = 0;
   // Clock, 10 ns period
   always #5 clk = ~clk;
   ebw_bus_ctrl #(.HALF_CYC(1)) ebw_bus_ctrl_inst
   (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_BUS_CONFIG_PIN_HI(cfg_hi),
    .I_BUS_CONFIG_PIN_LO(cfg_lo), .I_AD(ad_in), .O_AD(ad_out), .O_AD_OE_N(oe_n),
    .O_ADDR(addr), .O_ALE(ale), .O_RD_N(rd_n), .O_WR_N(wr_n),
    .O_UPPER_BYTE_ENABLE_N(ube_n));
   ebw_mem_model ebw_mem_model_inst
   (.i_clk(clk), .i_mux(cfg_hi ^ cfg_lo), .i_ad(ad_out), .i_addr(addr),
    .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_ube_n(ube_n), .o_ad(ad_in));
   // --------------------------------
   // Shared tasks
   // --------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask
   // One APB transfer, held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Straps held through reset
   task do_reset(input logic hi, input logic lo);
      @(posedge clk);
      cfg_hi <= hi;
      cfg_lo <= lo;
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   // Start a cycle, count active cycles, wait for idle
   task run(input logic [31:0] ctrl, input int len, input logic exp_ube);
      int n;
      logic u;
      n = 0;
      apb(1'b1, OFS_CTRL, ctrl);
      #1;
      u = ube_n;
      while ((ale || !rd_n || !wr_n) && n < 300)
      begin
         n++;
         @(posedge clk);
         #1;
      end
      chk(n, len);
      chk({31'h0, u}, {31'h0, exp_ube});
      chk({31'h0, oe_n}, 32'h1);
      n = 0;
      do
      begin
         apb(1'b0, OFS_STATUS, 32'h0);
         n++;
      end
      while (rd[0] !== 1'b0 && n < 50);
      polls = n;
      chk({31'h0, rd[0]}, 32'h0);
   endtask
   // --------------------------------
   // Scenarios
   // --------------------------------
   task t_reset;
      do_reset(1'b1, 1'b0);
      apb(1'b0, OFS_SYSCFG, 32'h0);
      chk(rd, 32'h80);
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask
   task t_mux;
      apb(1'b1, OFS_SYSCFG, 32'h1f);
      apb(1'b1, OFS_ADDR, 32'h10);
      apb(1'b1, OFS_WDATA, 32'ha5c3);
      run(32'h3, 6, 1'b0);
      apb(1'b1, OFS_SYSCFG, 32'h1c);
      run(32'h1, 12, 1'b0);
      apb(1'b0, OFS_RDATA, 32'h0);
      chk(rd, 32'ha5c3);
      apb(1'b1, OFS_ADDR, 32'h11);
      run(32'h5, 12, 1'b0);
      apb(1'b0, OFS_RDATA, 32'h0);
      chk(rd, 32'ha5);
      apb(1'b1, OFS_ADDR, 32'h10);
      run(32'h5, 12, 1'b1);
      apb(1'b0, OFS_RDATA, 32'h0);
      chk(rd, 32'hc3);
      apb(1'b1, OFS_SYSCFG, 32'h11c);
      apb(1'b1, OFS_ADDR, 32'h11);
      run(32'h5, 12, 1'b1);
      apb(1'b1, OFS_SYSCFG, 32'h0f);
      apb(1'b1, OFS_WDATA, 32'h77);
      run(32'h7, 6, 1'b0);
      chk(polls, 1);
      run(32'h1, 6, 1'b0);
      chk(polls, 2);
      apb(1'b0, OFS_RDATA, 32'h0);
      chk(rd, 32'h77c3);
   endtask
   task t_mux8;
      do_reset(1'b0, 1'b1);
      apb(1'b0, OFS_SYSCFG, 32'h0);
      chk(rd, 32'h40);
      apb(1'b1, OFS_SYSCFG, 32'h1f);
      apb(1'b1, OFS_ADDR, 32'h30);
      apb(1'b1, OFS_WDATA, 32'h5a);
      run(32'h3, 6, 1'b1);
      run(32'h1, 6, 1'b1);
      apb(1'b0, OFS_RDATA, 32'h0);
      chk(rd, 32'h5a);
      do_reset(1'b1, 1'b1);
      apb(1'b0, OFS_SYSCFG, 32'h0);
      chk(rd, 32'hc0);
   endtask
   task t_nmx;
      do_reset(1'b0, 1'b0);
      apb(1'b1, OFS_SYSCFG, 32'h1f);
      apb(1'b1, OFS_ADDR, 32'h20);
      apb(1'b1, OFS_WDATA, 32'h1234);
      run(32'h3, 4, 1'b0);
      apb(1'b1, OFS_SYSCFG, 32'h10);
      run(32'h1, 34, 1'b0);
      chk({16'h0, addr}, 32'h20);
      apb(1'b0, OFS_RDATA, 32'h0);
      chk(rd, 32'h1234);
   endtask
   task give_verdict;
      $display("Comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog well past the expected run
   initial
   begin
      #200000;
      errors++;
      give_verdict;
   end
   initial
   begin
      t_reset;
      t_mux;
      t_mux8;
      t_nmx;
      give_verdict;
   end
endmodule // testbench
`default_nettype wire
